// ### dma_bridge_cfg.svh
// Contract
// [R01] receive holds until descriptor ready and data
// [R02] packet spans several prefetched buffers in turn
// [R03] status written back after data written
// [R04] eop writeback three dwords, otherwise one
// [R05] completed flag set in written status
// [R06] user status valid only with last
// [R07] user control taken with first word
// [R08] transmit header built ahead of payload
// [R09] header low: control, fifteen zeros, begin offset
// [R10] header high: insert offset, checksum seed
// [R11] software zeroes seed if pseudo-header inserted
// [R12] receive footer stripped into user status
// [R13] status low: raw checksum, sixteen zeros
// [R14] status high: frame length, sixteen zeros
// [R15] framed fifo carries stream between domains; here both sides run on the one ref_clk
// [R16] fifo 512 entries of 40 bits
// [R17] mac stream clock from crystal source
// [R18] flags mark status halves equal zero
// [R19] tail byte mask carried unchanged
`ifndef DMA_BRIDGE_CFG_SVH
`define DMA_BRIDGE_CFG_SVH
`define FIFO_DEPTH 512
`define FIFO_WORD_BITS 40
`define HDR_ZERO_BITS 15
`define HDR_CTRL_BIT 31
`define FOOT_CSUM_MSB 31
`define FOOT_CSUM_LSB 16
`define FOOT_LEN_MSB 15
`define FOOT_LEN_LSB 0
`define STATUS_PAD 16'h0000
`define WB_DW_EOP 2'h3
`define WB_DW_MID 2'h1
`define BYTE_COUNT_BITS 20
`define TAIL_ALL 4'hF
`endif

// ### dma_bridge_pkg.sv
package dma_bridge_pkg;
  typedef struct packed {
    logic [31:0] data;
    logic [3:0] tailByteValid;
    logic sof;
    logic sop;
    logic eop;
    logic eof;
  } fifo_word_type;
  typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_HDR1 = 2'b01, TX_PAY = 2'b11} tx_state_type;
  typedef enum logic [1:0] {RX_WAIT = 2'b00, RX_PAY = 2'b01, RX_FOOT = 2'b11} rx_state_type;
endpackage : dma_bridge_pkg

// ### dma_mac_bridge.sv
`timescale 1ns/100ps
`include "dma_bridge_cfg.svh"
module dma_mac_bridge #(
  parameter int BYTE_COUNT_BITS = `BYTE_COUNT_BITS
) (
  // clock and reset; ref_clk must come from the crystal-derived mac clock [R17]
  input wire logic ref_clk,
  input wire logic rst,
  // host-to-card stream from the dma
  input wire logic [31:0] txData,
  input wire logic [3:0] txKeep,
  input wire logic txStreamFirst,
  input wire logic txLast,
  input wire logic txValid,
  input wire logic [63:0] txDescriptorUserControl,
  output logic txReady,
  // framed transmit stream to the mac
  output logic [31:0] macTxData,
  output logic [3:0] macTxTail,
  output logic macTxSof,
  output logic macTxSop,
  output logic macTxEop,
  output logic macTxEof,
  output logic macTxValid,
  input wire logic macTxReady,
  // framed receive stream from the mac
  input wire logic [31:0] macRxData,
  input wire logic [3:0] macRxTail,
  input wire logic macRxSop,
  input wire logic macRxEop,
  input wire logic macRxEof,
  input wire logic macRxValid,
  output logic macRxReady,
  // card-to-host stream to the dma
  output logic [31:0] rxHostData,
  output logic [3:0] rxHostKeep,
  output logic rxStreamLast,
  output logic [63:0] rxDescriptorUserStatus,
  output logic rxHostValid,
  input wire logic rxHostReady,
  // prefetched receive descriptors
  input wire logic descAvail,
  input wire logic [BYTE_COUNT_BITS-1:0] descBufSize,
  output logic descConsume,
  // descriptor status writeback
  input wire logic writeIdle,
  output logic wbValid,
  input wire logic wbReady,
  output logic [1:0] wbDwords,
  output logic wbComplete,
  output logic wbEop,
  output logic [BYTE_COUNT_BITS-1:0] wbByteCount,
  output logic [63:0] wbUserStatus,
  output logic wbUpperZero,
  output logic wbLowerZero
);
  import dma_bridge_pkg::*;

  if (BYTE_COUNT_BITS < 3 || BYTE_COUNT_BITS > 32)
    $error("dma_mac_bridge byte count width out of range");

  // ================================================================
  // state
  typedef struct packed {
    tx_state_type tx;
    logic [31:0] ctlHi;
    logic firstPay;
    logic [1:0] bufCnt;
    fifo_word_type buf0;
    fifo_word_type buf1;
    rx_state_type rx;
    logic heldValid;
    fifo_word_type held;
    logic footGot;
    logic [31:0] footWord;
    logic outValid;
    fifo_word_type out;
    logic outLast;
    logic [63:0] outStatus;
    logic [BYTE_COUNT_BITS-1:0] bufBytes;
    logic wbPend;
    logic wbEop;
    logic [BYTE_COUNT_BITS-1:0] wbBytes;
    logic [63:0] wbStatus;
    logic descTake;
  } bridge_state_type;

  bridge_state_type st_q, st_d;
  fifo_port_if fif ();
  logic outFree, hostAccept, macRxBeat, txPop, fifoWrEn, fifoRdEn;
  fifo_word_type fifoWrData;
  logic [BYTE_COUNT_BITS-1:0] byteSum;
  logic [31:0] footNow;

  function automatic logic [2:0] keepBytes(input logic [3:0] keep);
    keepBytes = 3'(keep[0]) + 3'(keep[1]) + 3'(keep[2]) + 3'(keep[3]);
  endfunction : keepBytes

  // the 512-word store stands between the dma and mac streams; here both sides share ref_clk [R15]
  frame_fifo #(.DEPTH(`FIFO_DEPTH)) store (.ref_clk(ref_clk), .rst(rst), .port(fif)); // [R16]
  assign fif.wrEn = fifoWrEn;
  assign fif.wrData = fifoWrData;
  assign fif.rdEn = fifoRdEn;

  // ================================================================
  // handshakes
  assign macTxValid = (st_q.bufCnt != 2'h0);
  assign txPop = macTxValid && macTxReady;
  // pops are issued only while the two-entry buffer can take the in-flight word too
  assign fifoRdEn = !fif.empty && ((2'(st_q.bufCnt) + 2'(fif.rdValid)) < 2'h2);
  assign rxHostValid = st_q.outValid && !st_q.wbPend;
  assign hostAccept = rxHostValid && rxHostReady;
  assign outFree = !st_q.outValid || (rxHostReady && !st_q.wbPend);
  assign macRxBeat = macRxValid && macRxReady;
  assign byteSum = st_q.bufBytes + BYTE_COUNT_BITS'(keepBytes(st_q.out.tailByteValid));
  assign footNow = st_q.footGot ? st_q.footWord : macRxData;

  always_comb
  begin
    st_d = st_q;
    txReady = 1'b0;
    fifoWrEn = 1'b0;
    fifoWrData = '0;
    macRxReady = 1'b0;
    st_d.descTake = 1'b0;

    // ================================================================
    // transmit header insert
    case (st_q.tx)
      TX_IDLE:
      begin
        // a stray word outside a packet is drained rather than left to block the stream
        txReady = txValid && !txStreamFirst;
        if (txValid && txStreamFirst && !fif.full)
        begin
          fifoWrEn = 1'b1; // [R08]
          fifoWrData.data = {txDescriptorUserControl[`HDR_CTRL_BIT], `HDR_ZERO_BITS'h0000,
                             txDescriptorUserControl[15:0]}; // [R09]
          fifoWrData.tailByteValid = `TAIL_ALL;
          fifoWrData.sof = 1'b1;
          st_d.ctlHi = txDescriptorUserControl[63:32]; // [R07]
          st_d.tx = TX_HDR1;
        end
      end
      TX_HDR1:
      begin
        if (!fif.full)
        begin
          fifoWrEn = 1'b1;
          // insert offset over seed; a zero seed from software passes straight through [R11]
          fifoWrData.data = st_q.ctlHi; // [R10]
          fifoWrData.tailByteValid = `TAIL_ALL;
          st_d.firstPay = 1'b1;
          st_d.tx = TX_PAY;
        end
      end
      TX_PAY:
      begin
        txReady = !fif.full;
        if (txValid && !fif.full)
        begin
          fifoWrEn = 1'b1;
          fifoWrData.data = txData;
          fifoWrData.tailByteValid = txKeep; // [R19]
          fifoWrData.sop = st_q.firstPay;
          fifoWrData.eop = txLast;
          fifoWrData.eof = txLast;
          st_d.firstPay = 1'b0;
          if (txLast)
            st_d.tx = TX_IDLE;
        end
      end
      default:
        st_d.tx = TX_IDLE;
    endcase

    // two-entry output buffer: a mac stall loses no word
    if (txPop)
    begin
      st_d.buf0 = st_q.buf1;
      st_d.bufCnt = st_q.bufCnt - 2'h1;
    end
    if (fif.rdValid)
    begin
      if (st_d.bufCnt == 2'h0)
        st_d.buf0 = fif.rdData;
      else
        st_d.buf1 = fif.rdData;
      st_d.bufCnt = st_d.bufCnt + 2'h1;
    end

    // ================================================================
    // receive footer strip; the last payload word waits for the footer
    if (hostAccept)
      st_d.outValid = 1'b0;
    case (st_q.rx)
      RX_WAIT:
      begin
        macRxReady = descAvail; // [R01]
        if (macRxBeat && macRxSop)
        begin
          st_d.held = {macRxData, macRxTail, 4'h0};
          st_d.heldValid = 1'b1;
          st_d.rx = macRxEop ? RX_FOOT : RX_PAY;
        end
      end
      RX_PAY:
      begin
        macRxReady = outFree;
        if (macRxBeat)
        begin
          st_d.outValid = 1'b1;
          st_d.out = st_q.held;
          st_d.outLast = 1'b0;
          st_d.outStatus = '0; // [R06]
          st_d.held = {macRxData, macRxTail, 4'h0};
          if (macRxEop)
            st_d.rx = RX_FOOT;
        end
      end
      RX_FOOT:
      begin
        macRxReady = outFree;
        if (macRxBeat)
        begin
          if (!st_q.footGot)
          begin
            st_d.footWord = macRxData;
            st_d.footGot = 1'b1;
          end
          if (macRxEof)
          begin
            st_d.outValid = 1'b1;
            st_d.out = st_q.held;
            st_d.outLast = 1'b1; // [R12]
            st_d.outStatus = {footNow[`FOOT_LEN_MSB:`FOOT_LEN_LSB], `STATUS_PAD,
                              footNow[`FOOT_CSUM_MSB:`FOOT_CSUM_LSB], `STATUS_PAD}; // [R13] [R14]
            st_d.heldValid = 1'b0;
            st_d.footGot = 1'b0;
            st_d.rx = RX_WAIT;
          end
        end
      end
      default:
        st_d.rx = RX_WAIT;
    endcase

    // ================================================================
    // buffer accounting and status writeback
    if (hostAccept)
    begin
      if (st_q.outLast || byteSum >= descBufSize)
      begin
        // a filled buffer closes and the next prefetched one takes over [R02]
        st_d.wbPend = 1'b1;
        st_d.wbEop = st_q.outLast;
        st_d.wbBytes = byteSum;
        st_d.wbStatus = st_q.outLast ? st_q.outStatus : 64'h0000_0000_0000_0000;
        st_d.bufBytes = '0;
        st_d.descTake = 1'b1;
      end
      else
        st_d.bufBytes = byteSum;
    end
    if (wbValid && wbReady)
      st_d.wbPend = 1'b0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  // ================================================================
  // outputs
  assign macTxData = st_q.buf0.data;
  assign macTxTail = st_q.buf0.tailByteValid;
  assign macTxSof = st_q.buf0.sof;
  assign macTxSop = st_q.buf0.sop;
  assign macTxEop = st_q.buf0.eop;
  assign macTxEof = st_q.buf0.eof;
  assign rxHostData = st_q.out.data;
  assign rxHostKeep = st_q.out.tailByteValid;
  assign rxStreamLast = st_q.outLast;
  assign rxDescriptorUserStatus = st_q.outStatus;
  assign descConsume = st_q.descTake;
  // writeback waits for the host writes of the packet to drain
  assign wbValid = st_q.wbPend && writeIdle; // [R03]
  assign wbDwords = st_q.wbEop ? `WB_DW_EOP : `WB_DW_MID; // [R04]
  assign wbComplete = 1'b1; // [R05]
  assign wbEop = st_q.wbEop;
  assign wbByteCount = st_q.wbBytes;
  assign wbUserStatus = st_q.wbStatus;
  assign wbUpperZero = (st_q.wbStatus[63:32] == 32'h0000_0000); // [R18]
  assign wbLowerZero = (st_q.wbStatus[31:0] == 32'h0000_0000); // [R18]

  // ================================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  hdr_low_word_a: assert property (fifoWrEn && fifoWrData.sof |-> fifoWrData.data[30:16] == 15'h0000 && // [R09]
    fifoWrData.data[15:0] == txDescriptorUserControl[15:0]) else $error("header low word malformed");
  hdr_high_word_a: assert property (fifoWrEn && fifoWrData.sof |=> st_q.tx == TX_HDR1 && // [R10]
    st_q.ctlHi == $past(txDescriptorUserControl[63:32])) else $error("header high word not captured");
  hdr_before_pay_a: assert property ((st_q.tx == TX_HDR1 || (st_q.tx == TX_IDLE && txStreamFirst)) |-> // [R08]
    !txReady) else $error("payload ahead of header");
  tail_carry_a: assert property (fifoWrEn && st_q.tx == TX_PAY |-> fifoWrData.tailByteValid == txKeep) // [R19]
    else $error("tail mask altered");
  rx_hold_a: assert property (st_q.rx == RX_WAIT && !descAvail |-> !macRxReady) // [R01]
    else $error("receive taken without descriptor");
  status_last_a: assert property (rxHostValid && !rxStreamLast |-> rxDescriptorUserStatus == 64'h0) // [R06]
    else $error("status outside last word");
  status_fmt_a: assert property (rxHostValid && rxStreamLast |-> rxDescriptorUserStatus[15:0] == 16'h0 && // [R13]
    rxDescriptorUserStatus[47:32] == 16'h0) else $error("status padding wrong");
  foot_strip_a: assert property (st_q.rx == RX_FOOT && macRxBeat && macRxEof |=> st_q.outValid && // [R12]
    st_q.outLast && st_q.rx == RX_WAIT) else $error("footer not turned into status");
  wb_dwords_a: assert property (wbValid |-> wbDwords == (wbEop ? 2'h3 : 2'h1)) // [R04]
    else $error("writeback dword count wrong");
  wb_after_a: assert property (hostAccept && rxStreamLast |=> st_q.wbPend && st_q.descTake && // [R03]
    (wbValid == writeIdle)) else $error("writeback not raised after last word");
  wb_flags_a: assert property (wbValid |-> wbComplete && wbUpperZero == (wbUserStatus[63:32] == 32'h0)) // [R18]
    else $error("status flags wrong");
  span_buf_a: assert property (hostAccept && !rxStreamLast && byteSum >= descBufSize |=> // [R02]
    st_q.bufBytes == '0 && !st_q.wbEop) else $error("buffer did not close when full");

  tx_frame_c: cover property (fifoWrEn && fifoWrData.eof);
  rx_frame_c: cover property (hostAccept && rxStreamLast);
  span_c: cover property (wbValid && !wbEop);
  tx_stall_c: cover property (st_q.bufCnt == 2'h2 && !macTxReady);
endmodule : dma_mac_bridge

// ### dma_mac_checksum_bridge_tb.sv
`timescale 1ns/100ps
module dma_mac_checksum_bridge_tb;
  import dma_bridge_pkg::*;
  typedef struct {logic [63:0] ctl; int nWords; logic [3:0] lastKeep;} tx_row_type;
  typedef struct {logic [31:0] foot; logic [3:0] tail; bit extra;} rx_row_type;
  // ==============================================================
  // signals
  logic ref_clk, rst = 1'b1;
  logic [31:0] txData = '0;
  logic [3:0] txKeep = 4'hF;
  logic txStreamFirst = 1'b0, txLast = 1'b0, txValid = 1'b0, txReady;
  logic [63:0] txDescriptorUserControl = '0;
  logic [31:0] macTxData, macRxData, rxHostData;
  logic [3:0] macTxTail, macRxTail, rxHostKeep;
  logic macTxSof, macTxSop, macTxEop, macTxEof, macTxValid, macTxReady;
  logic macRxSop, macRxEop, macRxEof, macRxValid, macRxReady;
  logic rxStreamLast, rxHostValid, descConsume, wbValid, wbComplete, wbEop, wbUpperZero, wbLowerZero;
  logic [63:0] rxDescriptorUserStatus, wbUserStatus;
  logic rxHostReady = 1'b0, descAvail = 1'b1, writeIdle = 1'b1, wbReady = 1'b0, hostSlow = 1'b0;
  logic [19:0] descBufSize = 20'h0_0800, wbByteCount;
  logic [1:0] wbDwords, sinkMode = 2'h0;
  logic [100:0] hostSeen[$];
  logic [89:0] wbSeen[$];
  int mismatches = 0, checked = 0, cycles = 0, consumeCount = 0;
  tx_row_type txRows[4] = '{
    '{64'h0032_ABCD_8000_000E, 1, 4'h1},
    '{64'h0028_0000_7FFF_0022, 2, 4'h3},
    '{64'hFFFF_FFFF_FFFF_FFFF, 3, 4'h7},
    '{64'h0000_0000_0000_0000, 2, 4'hF}
  };
  tx_row_type fillRow = '{64'h1234_5678_9ABC_DEF0, 600, 4'h1};
  rx_row_type rxRows[3] = '{'{32'h1234_0040, 4'h3, 1'b0}, '{32'h0000_0008, 4'hF, 1'b1}, '{32'hBEEF_0000, 4'h1, 1'b0}};
  dma_mac_bridge #(.BYTE_COUNT_BITS(20)) DUT (
    .ref_clk, .rst, .txData, .txKeep, .txStreamFirst, .txLast, .txValid, .txDescriptorUserControl, .txReady,
    .macTxData, .macTxTail, .macTxSof, .macTxSop, .macTxEop, .macTxEof, .macTxValid, .macTxReady,
    .macRxData, .macRxTail, .macRxSop, .macRxEop, .macRxEof, .macRxValid, .macRxReady,
    .rxHostData, .rxHostKeep, .rxStreamLast, .rxDescriptorUserStatus, .rxHostValid, .rxHostReady,
    .descAvail, .descBufSize, .descConsume, .writeIdle, .wbValid, .wbReady, .wbDwords, .wbComplete, .wbEop,
    .wbByteCount, .wbUserStatus, .wbUpperZero, .wbLowerZero
  );
  mac_partner_model partner (
    .ref_clk, .rst, .macTxData, .macTxTail, .macTxSof, .macTxSop, .macTxEop, .macTxEof, .macTxValid, .sinkMode,
    .macTxReady, .macRxData, .macRxTail, .macRxSop, .macRxEop, .macRxEof, .macRxValid, .macRxReady
  );
  // ==============================================================
  // clock, host side handshakes, timeout
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    cycles++;
    rxHostReady <= !hostSlow || cycles[1];
    wbReady <= !hostSlow || cycles[0];
    if (cycles == 5000)
    begin
      mismatches++;
      $display("Error at %0t: run did not finish", $time);
      complete_run();
    end
  end
  // status is recorded only with the last word, where it is valid
  always @(posedge ref_clk)
  begin
    if (rxHostValid === 1'b1 && rxHostReady === 1'b1)
      hostSeen.push_back({rxHostData, rxHostKeep, rxStreamLast,
                          rxStreamLast ? rxDescriptorUserStatus : 64'h0});
    if (wbValid === 1'b1 && wbReady === 1'b1)
      wbSeen.push_back({wbDwords, wbComplete, wbEop, wbByteCount, wbUserStatus, wbUpperZero, wbLowerZero});
    if (descConsume === 1'b1)
      consumeCount++;
    if (wbValid === 1'b1 && writeIdle !== 1'b1)
      check(128'h1, 128'h0, "writeback before host writes done");
  end
  // ==============================================================
  // tasks
  task automatic check(input logic [127:0] got, input logic [127:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check
  task automatic settle(input int txN, input int hostN, input int wbN);
    int guard;
    guard = 0;
    while ((partner.txSeen.size() < txN || hostSeen.size() < hostN || wbSeen.size() < wbN) && guard < 2000)
    begin
      @(posedge ref_clk);
      guard++;
    end
    @(posedge ref_clk);
    if (guard == 2000)
      check(128'h1, 128'h0, "expected traffic missing");
  endtask : settle
  // valid stays up between packets; tx_idle drops it once the burst is over
  task automatic send_tx(input tx_row_type row, input logic [31:0] base);
    int guard;
    for (int k = 0; k < row.nWords; k++)
    begin
      txData <= base + 32'(k);
      txKeep <= (k == row.nWords - 1) ? row.lastKeep : 4'hF;
      txStreamFirst <= (k == 0);
      txLast <= (k == row.nWords - 1);
      txValid <= 1'b1;
      txDescriptorUserControl <= (k == 0) ? row.ctl : ~row.ctl;
      guard = 0;
      do
      begin
        @(posedge ref_clk);
        guard++;
      end
      while (txReady !== 1'b1 && guard < 300);
    end
  endtask : send_tx
  task automatic tx_idle();
    txValid <= 1'b0;
    txData <= ~txData;
  endtask : tx_idle
  task automatic check_tx(input tx_row_type row, input logic [31:0] base);
    fifo_word_type exp;
    settle(row.nWords + 2, 0, 0);
    for (int k = -2; k < row.nWords; k++)
    begin
      if (k == -2)
        exp = {row.ctl[31], 15'h0000, row.ctl[15:0], 4'hF, 4'b1000};
      else if (k == -1)
        exp = {row.ctl[63:32], 4'hF, 4'b0000};
      else
        exp = {base + 32'(k), (k == row.nWords - 1) ? row.lastKeep : 4'hF, 1'b0, k == 0, {2{k == row.nWords - 1}}};
      check(128'(partner.txSeen.pop_front()), 128'(exp), "mac tx word");
    end
  endtask : check_tx
  task automatic send_rx(input rx_row_type row, input int nPay, input logic [31:0] base);
    for (int k = 0; k < nPay; k++)
      partner.send_beat(base + 32'(k), (k == nPay - 1) ? row.tail : 4'hF, k == 0, k == nPay - 1, 1'b0);
    partner.send_beat(row.foot, 4'hF, 1'b0, 1'b0, !row.extra);
    if (row.extra)
      partner.send_beat(~row.foot, 4'hF, 1'b0, 1'b0, 1'b1);
    partner.rx_idle();
  endtask : send_rx
  task automatic complete_run();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run
  // ==============================================================
  // main sequence
  initial
  begin
    logic [31:0] base;
    logic [63:0] st;
    repeat (10) @(posedge ref_clk);
    check(128'({macTxValid, rxHostValid, wbValid, descConsume}), 128'h0, "outputs in reset");
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    // a word without start-of-packet while idle is taken and dropped
    txValid <= 1'b1;
    txData <= 32'hDEAD_BEEF;
    @(posedge ref_clk);
    check(128'(txReady), 128'h1, "stray tx word not drained");
    $display("test reset done");
    foreach (txRows[r])
    begin
      sinkMode <= 2'(r % 2);
      send_tx(txRows[r], 32'h1000_0000 + 32'(r * 256));
    end
    tx_idle();
    foreach (txRows[r])
      check_tx(txRows[r], 32'h1000_0000 + 32'(r * 256));
    $display("test tx rows done");
    sinkMode <= 2'h2;
    fork
      send_tx(fillRow, 32'h5000_0000);
      begin
        repeat (700) @(posedge ref_clk);
        check(128'(txReady), 128'h0, "tx taken with full fifo");
        sinkMode <= 2'h0;
      end
    join
    tx_idle();
    check_tx(fillRow, 32'h5000_0000);
    $display("test tx fill done");
    descAvail <= 1'b0;
    foreach (rxRows[r])
    begin
      base = 32'hA000_0000 + 32'(r * 16);
      hostSlow <= r[0];
      @(posedge ref_clk);
      fork
        send_rx(rxRows[r], 2, base);
        if (r == 0)
        begin
          repeat (10) @(posedge ref_clk);
          check(128'(macRxReady), 128'h0, "rx taken without descriptor");
          descAvail <= 1'b1;
        end
      join
      settle(0, 2, 1);
      st = {rxRows[r].foot[15:0], 16'h0000, rxRows[r].foot[31:16], 16'h0000};
      check(hostSeen.pop_front(), {base, 4'hF, 1'b0, 64'h0}, "host word");
      check(hostSeen.pop_front(), {base + 32'h1, rxRows[r].tail, 1'b1, st}, "host last word");
      check(wbSeen.pop_front(), {2'h3, 2'h3, 20'(4 + $countones(rxRows[r].tail)), st, st[63:32] == 0,
                                 st[31:0] == 0}, "eop writeback");
    end
    $display("test rx rows done");
    descBufSize <= 20'h0_0004;
    writeIdle <= 1'b0;
    hostSlow <= 1'b0;
    @(posedge ref_clk);
    // a beat without start-of-packet while waiting must be dropped
    partner.send_beat(32'hDEAD_BEEF, 4'hF, 1'b0, 1'b1, 1'b1);
    fork
      send_rx(rxRows[0], 3, 32'hC000_0000);
      begin
        repeat (30) @(posedge ref_clk);
        writeIdle <= 1'b1;
      end
    join
    settle(0, 3, 3);
    st = {16'h0040, 16'h0000, 16'h1234, 16'h0000};
    for (int k = 0; k < 3; k++)
      check(hostSeen.pop_front(), {32'hC000_0000 + 32'(k), k == 2 ? 4'h3 : 4'hF, k == 2, k == 2 ? st : 64'h0},
            "spanned host word");
    check(wbSeen.pop_front(), {2'h1, 2'h2, 20'h0_0004, 64'h0, 2'h3}, "first buffer writeback");
    check(wbSeen.pop_front(), {2'h1, 2'h2, 20'h0_0004, 64'h0, 2'h3}, "second buffer writeback");
    check(wbSeen.pop_front(), {2'h3, 2'h3, 20'h0_0002, st, 2'h0}, "last buffer writeback");
    check(128'(consumeCount), 128'h6, "descriptors closed");
    $display("test rx spanning done");
    complete_run();
  end
endmodule : dma_mac_checksum_bridge_tb

// ### fifo_port_if.sv
`timescale 1ns/100ps
interface fifo_port_if;
  logic wrEn;
  dma_bridge_pkg::fifo_word_type wrData;
  logic full;
  logic rdEn;
  dma_bridge_pkg::fifo_word_type rdData;
  logic rdValid;
  logic empty;
  modport store (input wrEn, input wrData, output full, input rdEn, output rdData, output rdValid, output empty);
  modport user (output wrEn, output wrData, input full, output rdEn, input rdData, input rdValid, input empty);
endinterface : fifo_port_if

// ### frame_fifo.sv
`timescale 1ns/100ps
`include "dma_bridge_cfg.svh"
module frame_fifo #(
  parameter int DEPTH = `FIFO_DEPTH
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // fifo port
  fifo_port_if.store port
);
  import dma_bridge_pkg::*;
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH || $bits(fifo_word_type) != `FIFO_WORD_BITS)
    $error("frame_fifo needs a power-of-two depth and 40-bit words"); // [R16]

  typedef struct packed {
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;
    fifo_word_type rdData;
    logic rdValid;
  } fifo_state_type;

  fifo_state_type st_q, st_d;
  fifo_word_type mem [DEPTH]; // [R16]
  logic doWr, doRd;

  assign doWr = port.wrEn && (st_q.count != (AW+1)'(DEPTH));
  assign doRd = port.rdEn && (st_q.count != '0);
  assign port.full = (st_q.count == (AW+1)'(DEPTH));
  assign port.empty = (st_q.count == '0);
  assign port.rdData = st_q.rdData;
  assign port.rdValid = st_q.rdValid;

  always_comb
  begin
    st_d = st_q;
    st_d.rdValid = doRd;
    if (doWr)
      st_d.wrPtr = st_q.wrPtr + 1'b1;
    if (doRd)
    begin
      // framing bits and tail mask leave exactly as stored
      st_d.rdData = mem[st_q.rdPtr]; // [R19]
      st_d.rdPtr = st_q.rdPtr + 1'b1;
    end
    st_d.count = st_q.count + (AW+1)'(doWr) - (AW+1)'(doRd);
  end

  always_ff @(posedge ref_clk)
  begin
    if (doWr)
      mem[st_q.wrPtr] <= port.wrData;
    if (rst)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  fifo_count_a: assert property (@(posedge ref_clk) disable iff (rst)
    (doWr && !doRd) |=> st_q.count == $past(st_q.count) + 1'b1) else $error("fifo count lost a write"); // [R16]
endmodule : frame_fifo

// ### mac_partner_model.sv
`timescale 1ns/100ps
// ==============================================================
// mac side: frame sink with stalls, beat source for receive
module mac_partner_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // transmit sink
  input wire logic [31:0] macTxData,
  input wire logic [3:0] macTxTail,
  input wire logic macTxSof,
  input wire logic macTxSop,
  input wire logic macTxEop,
  input wire logic macTxEof,
  input wire logic macTxValid,
  input wire logic [1:0] sinkMode,
  output logic macTxReady,
  // receive source
  output logic [31:0] macRxData,
  output logic [3:0] macRxTail,
  output logic macRxSop,
  output logic macRxEop,
  output logic macRxEof,
  output logic macRxValid,
  input wire logic macRxReady
);
  import dma_bridge_pkg::*;
  fifo_word_type txSeen[$];
  logic [2:0] stallCnt = 3'h0;
  initial
  begin
    macTxReady = 1'b0;
    macRxData = 32'h0000_0000;
    macRxTail = 4'h0;
    {macRxSop, macRxEop, macRxEof, macRxValid} = 4'h0;
  end
  // mode 0 takes every word, 1 stalls half the time, 2 holds off to fill the buffer
  always @(posedge ref_clk)
  begin
    if (macTxValid === 1'b1 && macTxReady === 1'b1)
      txSeen.push_back({macTxData, macTxTail, macTxSof, macTxSop, macTxEop, macTxEof});
    stallCnt <= stallCnt + 3'h1;
    macTxReady <= !rst && (sinkMode == 2'h0 || (sinkMode == 2'h1 && stallCnt[1]));
  end
  task automatic send_beat(input logic [31:0] data, input logic [3:0] tail, input logic sop, input logic eop,
                           input logic eof);
    int guard;
    guard = 0;
    macRxData <= data;
    macRxTail <= tail;
    macRxSop <= sop;
    macRxEop <= eop;
    macRxEof <= eof;
    macRxValid <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      guard++;
    end
    while (macRxReady !== 1'b1 && guard < 200);
  endtask : send_beat
  // released lines show the inverse so a stale beat is never read as fresh
  task automatic rx_idle();
    macRxValid <= 1'b0;
    macRxData <= ~macRxData;
    macRxTail <= ~macRxTail;
    {macRxSop, macRxEop, macRxEof} <= ~{macRxSop, macRxEop, macRxEof};
  endtask : rx_idle
endmodule : mac_partner_model
